// >>> design/bte_ctrl.sv
// Purpose: Run bus cycles and turn their termination into results and cache actions
// Assumes: Core offers one request at a time; pins are asynchronous to core_clk_i
// Notes: Termination pins are seen two cycles late through the synchroniser
//
// Function
// - Breakpoint cycle: type 3, address 0, modifier 0
// - Breakpoint cycle ended gives illegal instruction exception
// - Decode pair: ok, error, retry, wait
// - Both asserted on the first beat reruns the cycle, no error
// - Bus error ends the access at once
// - Error in any line beat aborts the line
// - Prefetch error held until used, dropped on flush
// - Later line read beat error traps only if wanted
// - Misaligned line operand error traps at once
// - Write or wanted read error traps at once
// - Fill invalidates victim first, stays invalid on error
// - Dirty victim restored from push buffer on error
// - Push error keeps or invalidates line by source
// - Write-through updates cache first, line stays valid
// - Fp state save error leaves frame corrupt
// - Retry reruns same address and attributes, except snooped push
// - Retry on later line beat counts as error
`timescale 1ns/10ps
module bte_ctrl
  import bte_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Core request side
  input wire logic req_valid_i,
  input bte_req_t req_i,
  output logic req_ready_o,
  input wire logic push_snooped_i,
  input wire logic instr_use_i,
  input wire logic instr_flush_i,
  // Core result side
  output logic done_o,
  output bte_res_t result_o,
  output logic exc_access_o,
  output logic exc_illegal_o,
  output logic err_pending_o,
  output logic fp_frame_bad_o,
  // Cache action strobes
  output logic pre_inval_o,
  output logic wt_update_o,
  output logic no_fill_o,
  output logic restore_dirty_o,
  output logic keep_valid_o,
  output logic line_inval_o,
  // External bus
  output logic [31:0] addr_o,
  output logic transfer_type_hi_o,
  output logic transfer_type_lo_o,
  output logic [2:0] transfer_modifier_o,
  output logic write_o,
  output logic start_o,
  output logic in_progress_o,
  input wire logic transfer_ack_n_i,
  input wire logic error_ack_n_i
);

  bte_state_t s_q;  // Registered state
  bte_state_t s_d;  // Next state
  bte_term_t term;  // Decoded pins, valid in the bus state
  logic is_line;    // Current access is a four beat line
  logic is_write;   // Current access drives data out

  // Decoder sees only the second synchroniser stage
  bte_term_dec u_dec (
    .ack_n_i(s_q.ack_s2),
    .err_n_i(s_q.err_s2),
    .term_o(term)
  );

  // Kind helpers
  assign is_line = (s_q.req.kind == BTE_K_LINE_RD) || (s_q.req.kind == BTE_K_LINE_WR) ||
                   (s_q.req.kind == BTE_K_PUSH);
  assign is_write = (s_q.req.kind == BTE_K_WR) || (s_q.req.kind == BTE_K_LINE_WR) ||
                    (s_q.req.kind == BTE_K_PUSH);

  // Next state
  always_comb begin
    logic bus_err;
    logic [1:0] nxt;
    bus_err = 1'b0;
    nxt = 2'(s_q.beat + 2'h1);
    s_d = s_q;
    // Two flip-flop synchroniser for both pins
    s_d.ack_s1 = transfer_ack_n_i;
    s_d.ack_s2 = s_q.ack_s1;
    s_d.err_s1 = error_ack_n_i;
    s_d.err_s2 = s_q.err_s1;
    // Strobes last one cycle
    s_d.start = 1'b0;
    s_d.done = 1'b0;
    s_d.exc_access = 1'b0;
    s_d.exc_illegal = 1'b0;
    s_d.no_fill = 1'b0;
    s_d.restore_dirty = 1'b0;
    s_d.keep_valid = 1'b0;
    s_d.line_inval = 1'b0;
    s_d.pre_inval = 1'b0;
    s_d.wt_update = 1'b0;
    s_d.fp_bad = 1'b0;
    // Held prefetch error: trap on use, drop on branch or task switch
    if (instr_use_i && s_q.err_pend) begin
      s_d.exc_access = 1'b1;
    end
    if (instr_use_i || instr_flush_i) begin
      s_d.err_pend = 1'b0;
    end
    case (s_q.st)
      BTE_ST_IDLE: begin
        if (req_valid_i) begin
          // Latch the request and start the first cycle
          s_d.req = req_i;
          s_d.beat = BTE_FIRST_BEAT;
          s_d.st = BTE_ST_BUS;
          s_d.start = 1'b1;
          s_d.in_prog = 1'b1;
          if (req_i.kind == BTE_K_BREAKPOINT_INSTR) begin
            s_d.addr = BTE_BREAKPOINT_INSTR_ADDR;
            s_d.tt = BTE_TT_ACK;
            s_d.tm = BTE_BREAKPOINT_INSTR_TM;
          end else begin
            s_d.addr = req_i.addr;
            s_d.tt = BTE_TT_NORMAL;
            s_d.tm = req_i.tm;
          end
          // Cache actions that must precede the bus cycle
          s_d.pre_inval = (req_i.kind == BTE_K_LINE_RD) && req_i.replaces_valid;
          s_d.wt_update = (req_i.kind == BTE_K_WR) && req_i.write_thru;
        end
      end
      default: begin
        case (term)
          BTE_T_WAIT: begin
            // Keep waiting; the outside monitor must end a dead cycle
          end
          BTE_T_OK: begin
            if (is_line && (s_q.beat != BTE_LAST_BEAT)) begin
              // Next long word of the line
              s_d.beat = nxt;
              if (s_q.req.burst_inh) begin
                s_d.start = 1'b1;
                s_d.addr[BTE_BEAT_LSB +: 2] = nxt;
              end
            end else begin
              s_d.st = BTE_ST_IDLE;
              s_d.in_prog = 1'b0;
              s_d.done = 1'b1;
              s_d.result = BTE_RES_OK;
              s_d.exc_illegal = (s_q.req.kind == BTE_K_BREAKPOINT_INSTR);
            end
          end
          BTE_T_RETRY: begin
            if (s_q.beat != BTE_FIRST_BEAT) begin
              bus_err = 1'b1;
            end else if ((s_q.req.kind == BTE_K_PUSH) && push_snooped_i) begin
              // Snooped push is dropped instead of rerun
              s_d.st = BTE_ST_IDLE;
              s_d.in_prog = 1'b0;
              s_d.done = 1'b1;
              s_d.result = BTE_RES_CANCEL;
            end else begin
              // Rerun with the held address and attributes
              s_d.start = 1'b1;
            end
          end
          default: begin
            bus_err = 1'b1;
          end
        endcase
      end
    endcase
    // Bus error: end the access now, skip remaining beats
    if (bus_err) begin
      s_d.st = BTE_ST_IDLE;
      s_d.in_prog = 1'b0;
      s_d.done = 1'b1;
      s_d.result = BTE_RES_ERR;
      case (s_q.req.kind)
        BTE_K_BREAKPOINT_INSTR: s_d.exc_illegal = 1'b1;
        BTE_K_WR, BTE_K_LINE_WR: begin
          s_d.exc_access = 1'b1;
          s_d.fp_bad = s_q.req.fp_save;
        end
        BTE_K_PUSH: begin
          s_d.keep_valid = s_q.req.push_after_fill;
          s_d.line_inval = s_q.req.push_explicit;
          s_d.exc_access = s_q.req.push_explicit;
        end
        default: begin
          if (s_q.req.kind == BTE_K_LINE_RD) begin
            s_d.no_fill = 1'b1;
            s_d.restore_dirty = s_q.req.dirty_victim;
          end
          if (s_q.req.prefetch) begin
            s_d.err_pend = 1'b1;
          end else if (s_q.req.kind == BTE_K_RD) begin
            s_d.exc_access = 1'b1;
          end else if (s_q.req.want_valid && (s_q.req.want_word == s_q.beat)) begin
            s_d.exc_access = 1'b1;
          end else if (s_q.req.misaligned && (s_q.beat < BTE_MIS_BEATS)) begin
            s_d.exc_access = 1'b1;
          end
        end
      endcase
    end
  end

  // State register, synchronous reset
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      s_q <= BTE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state
  assign req_ready_o = (s_q.st == BTE_ST_IDLE);
  assign done_o = s_q.done;
  assign result_o = s_q.result;
  assign exc_access_o = s_q.exc_access;
  assign exc_illegal_o = s_q.exc_illegal;
  assign err_pending_o = s_q.err_pend;
  assign fp_frame_bad_o = s_q.fp_bad;
  assign pre_inval_o = s_q.pre_inval;
  assign wt_update_o = s_q.wt_update;
  assign no_fill_o = s_q.no_fill;
  assign restore_dirty_o = s_q.restore_dirty;
  assign keep_valid_o = s_q.keep_valid;
  assign line_inval_o = s_q.line_inval;
  assign addr_o = s_q.addr;
  assign transfer_type_hi_o = s_q.tt[1];
  assign transfer_type_lo_o = s_q.tt[0];
  assign transfer_modifier_o = s_q.tm;
  assign write_o = is_write && s_q.in_prog;
  assign start_o = s_q.start;
  assign in_progress_o = s_q.in_prog;

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  logic in_bus;
  assign in_bus = (s_q.st == BTE_ST_BUS);

  a_breakpoint_instr_attrs: assert property (start_o && (s_q.req.kind == BTE_K_BREAKPOINT_INSTR) |->
    (addr_o == 32'h0) && transfer_type_hi_o && transfer_type_lo_o &&
    (transfer_modifier_o == 3'h0)) else $error("bad breakpoint cycle attrs");
  a_breakpoint_instr_illegal: assert property (in_bus && (s_q.req.kind == BTE_K_BREAKPOINT_INSTR) &&
    ((term == BTE_T_OK) || (term == BTE_T_ERR)) |=> done_o && exc_illegal_o && !exc_access_o)
    else $error("breakpoint end without illegal trap");
  a_wait_holds: assert property (in_bus && (term == BTE_T_WAIT) |=> in_bus && !done_o &&
    $stable(addr_o)) else $error("wait state ended cycle");
  a_retry_rerun: assert property (in_bus && (term == BTE_T_RETRY) && (s_q.beat == 2'h0) &&
    (s_q.req.kind != BTE_K_PUSH) |=> start_o && in_bus && (addr_o == $past(addr_o)) &&
    !exc_access_o) else $error("retry did not rerun");
  // The ready cycle may already take a new request, so the end is judged in the done cycle
  a_err_ends: assert property (in_bus && (term == BTE_T_ERR) |=> done_o &&
    (result_o == BTE_RES_ERR) && !in_bus && !start_o) else $error("error did not end");
  a_line_abort: assert property (in_bus && is_line && (s_q.beat != 2'h3) &&
    (term == BTE_T_ERR) |=> !in_bus && !in_progress_o && done_o)
    else $error("line not aborted");
  a_late_retry: assert property (in_bus && (s_q.beat != 2'h0) && (term == BTE_T_RETRY) |=>
    (result_o == BTE_RES_ERR) && done_o) else $error("late retry not an error");
  a_write_trap: assert property (in_bus && (term == BTE_T_ERR) &&
    ((s_q.req.kind == BTE_K_WR) || (s_q.req.kind == BTE_K_LINE_WR)) |=> exc_access_o)
    else $error("write error not trapped");
  a_pref_defer: assert property (in_bus && (term == BTE_T_ERR) && s_q.req.prefetch &&
    (s_q.req.kind == BTE_K_RD) |=> err_pending_o && !exc_access_o)
    else $error("prefetch error not deferred");
  a_fill_inval: assert property (start_o && (s_q.req.kind == BTE_K_LINE_RD) &&
    (s_q.beat == 2'h0) && $rose(in_progress_o) |-> pre_inval_o == s_q.req.replaces_valid)
    else $error("victim not invalidated first");
  a_dirty_back: assert property (in_bus && (term == BTE_T_ERR) &&
    (s_q.req.kind == BTE_K_LINE_RD) |=> no_fill_o &&
    (restore_dirty_o == $past(s_q.req.dirty_victim)))
    else $error("dirty line not restored");
  a_push_line: assert property (in_bus && (term == BTE_T_ERR) && (s_q.req.kind == BTE_K_PUSH) |=>
    (keep_valid_o == $past(s_q.req.push_after_fill)) &&
    (line_inval_o == $past(s_q.req.push_explicit)))
    else $error("push error line state wrong");

  c_breakpoint_instr: cover property (done_o && exc_illegal_o);
  c_retry: cover property (in_bus && (term == BTE_T_RETRY) ##1 start_o);
  c_line_ok: cover property (done_o && (result_o == BTE_RES_OK) && no_fill_o == 1'b0 && is_line);
  c_defer_use: cover property (err_pending_o ##[1:20] exc_access_o);

endmodule : bte_ctrl

// >>> design/bte_pkg.sv
// Purpose: Shared types and constants for the bus termination and error control block
// Assumes: One bus clock; termination inputs are active low pins
// Notes: Request, bus drive and block state travel as packed structs
package bte_pkg;

  // Transfer type codes
  localparam logic [1:0] BTE_TT_NORMAL = 2'h0;  // Ordinary access
  localparam logic [1:0] BTE_TT_ACK = 2'h3;     // Acknowledge cycle
  // Breakpoint acknowledge attributes
  localparam logic [31:0] BTE_BREAKPOINT_INSTR_ADDR = 32'h0000_0000;
  localparam logic [2:0] BTE_BREAKPOINT_INSTR_TM = 3'h0;
  // Line geometry: four long words, beat index in address bits 3:2
  localparam logic [1:0] BTE_FIRST_BEAT = 2'h0;
  localparam logic [1:0] BTE_LAST_BEAT = 2'h3;
  localparam int BTE_BEAT_LSB = 2;
  // Misaligned operand spans the first two beats only
  localparam logic [1:0] BTE_MIS_BEATS = 2'h2;

  // Kind of access asked for by the core
  typedef enum logic [2:0] {
    BTE_K_RD, BTE_K_WR, BTE_K_LINE_RD, BTE_K_LINE_WR, BTE_K_PUSH, BTE_K_BREAKPOINT_INSTR
  } bte_kind_t;

  // Decoded termination pair
  typedef enum logic [1:0] {
    BTE_T_WAIT, BTE_T_OK, BTE_T_ERR, BTE_T_RETRY
  } bte_term_t;

  // Outcome of a finished access
  typedef enum logic [1:0] {
    BTE_RES_OK, BTE_RES_ERR, BTE_RES_CANCEL
  } bte_res_t;

  // Controller states
  typedef enum logic {BTE_ST_IDLE, BTE_ST_BUS} bte_st_t;

  // One access request from the core
  typedef struct packed {
    bte_kind_t kind;
    logic [31:0] addr;
    logic [2:0] tm;          // Transfer modifier for ordinary cycles
    logic burst_inh;         // Line done as four single cycles
    logic prefetch;          // Instruction prefetch read
    logic want_valid;        // Execution unit wants one long word
    logic [1:0] want_word;   // Which long word it wants
    logic misaligned;        // Operand straddles beats 0 and 1
    logic write_thru;        // Write to a write-through page
    logic replaces_valid;    // Fill replaces a valid line
    logic dirty_victim;      // Replaced line is dirty and sits in the push buffer
    logic push_after_fill;   // Push follows a replacement read
    logic push_explicit;     // Push forced by the cache push instruction
    logic fp_save;           // Write belongs to the fp state save instruction
  } bte_req_t;

  // Whole block state
  typedef struct packed {
    bte_st_t st;
    logic [1:0] beat;
    bte_req_t req;
    logic ack_s1;
    logic ack_s2;
    logic err_s1;
    logic err_s2;
    logic [31:0] addr;
    logic [1:0] tt;
    logic [2:0] tm;
    logic start;
    logic in_prog;
    logic done;
    bte_res_t result;
    logic exc_access;
    logic exc_illegal;
    logic err_pend;
    logic no_fill;
    logic restore_dirty;
    logic keep_valid;
    logic line_inval;
    logic pre_inval;
    logic wt_update;
    logic fp_bad;
  } bte_state_t;

  // Reset value: idle, pins seen as negated
  localparam bte_state_t BTE_RST = '{st: BTE_ST_IDLE, result: BTE_RES_OK, req: '0,
    ack_s1: 1'b1, ack_s2: 1'b1, err_s1: 1'b1, err_s2: 1'b1, default: '0};

endpackage : bte_pkg

// >>> design/bte_term_dec.sv
// Purpose: Decode the synchronised termination pair into one of four outcomes
// Assumes: Inputs already pass the two-stage synchroniser
// Notes: Purely combinational
`timescale 1ns/10ps
module bte_term_dec
  import bte_pkg::*;
(
  // Synchronised active low pins
  input wire logic ack_n_i,
  input wire logic err_n_i,
  // Decoded outcome
  output bte_term_t term_o
);

  // Both asserted is a retry, never an error
  always_comb begin
    case ({ack_n_i, err_n_i})
      2'b01: term_o = BTE_T_OK;
      2'b10: term_o = BTE_T_ERR;
      2'b00: term_o = BTE_T_RETRY;
      default: term_o = BTE_T_WAIT;
    endcase
  end

endmodule : bte_term_dec

// >>> test/bte_bus_slave.sv
// Purpose: Bus slave and timeout monitor that terminate the block's bus cycles
// Assumes: One wait state per beat; pins idle negated (high)
// Notes: Mode 0 ok, 1 error, 2 retry, 3 silent slave ended by the monitor
`timescale 1ns/10ps
module bte_bus_slave
  import bte_pkg::*;
(
  // Clock
  input wire logic core_clk_i,
  // Bus from the block
  input wire logic start_i,
  input wire logic in_progress_i,
  // Scenario controls
  input wire logic [1:0] mode_i,
  input wire logic [1:0] err_beat_i,
  input wire logic [7:0] tmo_i,
  // Termination pins
  output logic transfer_ack_n_o,
  output logic error_ack_n_o
);
  logic [1:0] beat; // Beat being answered
  logic retried; // Retry is given once only
  logic [1:0] term; // Ack and error asserted
  // One cycle at a time; the block sees pins two edges late, so wait before re-checking
  initial begin
    transfer_ack_n_o = 1'b1;
    error_ack_n_o = 1'b1;
    forever begin
      @(posedge core_clk_i iff start_i);
      beat = 2'h0;
      retried = 1'b0;
      do begin
        @(posedge core_clk_i);
        if (mode_i == 2'h3) begin
          // Nobody acknowledges: monitor ends the cycle
          repeat (tmo_i) @(posedge core_clk_i);
          term = 2'b01;
        end else if (beat == err_beat_i && !retried) begin
          term = (mode_i == 2'h1) ? 2'b01 : (mode_i == 2'h2) ? 2'b11 : 2'b10;
        end else begin
          term = 2'b10;
        end
        // Both pins change on one edge and hold for exactly one edge
        transfer_ack_n_o <= !term[1];
        error_ack_n_o <= !term[0];
        @(posedge core_clk_i);
        {transfer_ack_n_o, error_ack_n_o} <= 2'b11;
        if (term == 2'b11 && beat == 2'h0) retried = 1'b1;
        else beat = beat + 2'h1;
        repeat (3) @(posedge core_clk_i);
        #1;
      end while (in_progress_i === 1'b1);
    end
  end
endmodule : bte_bus_slave

// >>> test/bte_ctrl_tb_top.sv
// Purpose: Self-checking bench for the bus termination controller
// Assumes: Slave model terminates every cycle it sees start
// Notes: A recorder ORs all strobes per access so pulses are never missed
`timescale 1ns/10ps
module bte_ctrl_tb_top;
  import bte_pkg::*;
  // Strobe positions in the recorded flag word
  localparam logic [8:0] EA = 9'h100, EI = 9'h080, FB = 9'h040, PI = 9'h020, WT = 9'h010;
  localparam logic [8:0] NF = 9'h008, RS = 9'h004, KV = 9'h002, LI = 9'h001;
  logic core_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, instr_use = 1'b0, instr_flush = 1'b0;
  bte_req_t req = '0;
  logic [1:0] mode = 2'h0, ebeat = 2'h0;
  logic [7:0] tmo = 8'h0;
  logic clr = 1'b0, fin = 1'b0;
  logic snoop = 1'b0; // Snoop hit during a retried push
  logic wr1; // Write direction at first start
  logic req_ready_o, done_o, exc_access_o, exc_illegal_o, err_pending_o, fp_frame_bad_o;
  logic pre_inval_o, wt_update_o, no_fill_o, restore_dirty_o, keep_valid_o, line_inval_o;
  logic [31:0] addr_o, addr2;
  logic tt_hi, tt_lo, write_o, start_o, in_progress_o, ack_n, err_n;
  logic [2:0] tm_o;
  bte_res_t result_o, res;
  logic [8:0] fl; // Strobes seen this access
  logic [36:0] bus1; // Address, type, modifier at first start
  int starts, cyc, err_count = 0, total_checks = 0;
  always #2 core_clk = ~core_clk;
  bte_ctrl i_dut (.core_clk_i(core_clk), .resetn_i(resetn), .req_valid_i(req_valid),
    .req_i(req), .req_ready_o(req_ready_o), .push_snooped_i(snoop), .instr_use_i(instr_use),
    .instr_flush_i(instr_flush), .done_o(done_o), .result_o(result_o),
    .exc_access_o(exc_access_o), .exc_illegal_o(exc_illegal_o), .err_pending_o(err_pending_o),
    .fp_frame_bad_o(fp_frame_bad_o), .pre_inval_o(pre_inval_o), .wt_update_o(wt_update_o),
    .no_fill_o(no_fill_o), .restore_dirty_o(restore_dirty_o), .keep_valid_o(keep_valid_o),
    .line_inval_o(line_inval_o), .addr_o(addr_o), .transfer_type_hi_o(tt_hi),
    .transfer_type_lo_o(tt_lo), .transfer_modifier_o(tm_o), .write_o(write_o),
    .start_o(start_o), .in_progress_o(in_progress_o), .transfer_ack_n_i(ack_n),
    .error_ack_n_i(err_n));
  bte_bus_slave i_slave (.core_clk_i(core_clk), .start_i(start_o), .in_progress_i(in_progress_o),
    .mode_i(mode), .err_beat_i(ebeat), .tmo_i(tmo), .transfer_ack_n_o(ack_n),
    .error_ack_n_o(err_n));
  // Recorder: cleared with each request, then gathers strobes, starts and the result
  always @(posedge core_clk) begin
    if (clr) begin
      fin <= 1'b0;
      fl <= '0;
      starts <= 0;
      cyc <= 0;
    end else begin
      if (!fin) cyc <= cyc + 1;
      fl <= fl | {exc_access_o, exc_illegal_o, fp_frame_bad_o, pre_inval_o, wt_update_o,
        no_fill_o, restore_dirty_o, keep_valid_o, line_inval_o};
      if (done_o === 1'b1) begin
        fin <= 1'b1;
        res <= result_o;
      end
      if (start_o === 1'b1) begin
        starts <= starts + 1;
        if (starts == 0) begin
          bus1 <= {addr_o, tt_hi, tt_lo, tm_o};
          wr1 <= write_o;
        end else begin
          addr2 <= addr_o;
        end
      end
    end
  end
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic bte_req_t mk(input bte_kind_t k);
    bte_req_t r;
    r = '0;
    r.kind = k;
    r.addr = 32'h0000_1230;
    r.tm = 3'h5;
    return r;
  endfunction : mk
  // Issue one access with a slave behaviour and wait, bounded, for its end
  task automatic run(input bte_req_t r, input logic [1:0] m, input logic [1:0] b,
      input logic [7:0] t);
    @(posedge core_clk);
    req <= r;
    req_valid <= 1'b1;
    mode <= m;
    ebeat <= b;
    tmo <= t;
    clr <= 1'b1;
    @(posedge core_clk);
    req_valid <= 1'b0;
    clr <= 1'b0;
    @(negedge core_clk);
    chk(req_ready_o, 1'b0);
    for (int n = 0; n < 400 && fin !== 1'b1; n++) @(negedge core_clk);
    chk(fin, 1'b1);
  endtask : run
  // Use or flush pulse towards the held prefetch error
  task automatic pulse(input logic f);
    @(posedge core_clk);
    if (f) instr_flush <= 1'b1;
    else instr_use <= 1'b1;
    @(posedge core_clk);
    {instr_use, instr_flush} <= 2'b00;
    repeat (3) @(negedge core_clk);
  endtask : pulse
  task automatic t_breakpoint_instr;
    for (int i = 0; i < 2; i++) begin
      run(mk(BTE_K_BREAKPOINT_INSTR), i[1:0], 2'h0, 8'h0);
      chk(bus1, {BTE_BREAKPOINT_INSTR_ADDR, BTE_TT_ACK, BTE_BREAKPOINT_INSTR_TM});
      chk(fl & (EI | EA), EI);
    end
    $display("test breakpoint_instr end");
  endtask : t_breakpoint_instr
  task automatic t_rd;
    run(mk(BTE_K_RD), 2'h0, 2'h0, 8'h0);
    chk(res, BTE_RES_OK);
    chk({bus1, wr1}, {32'h0000_1230, BTE_TT_NORMAL, 3'h5, 1'b0});
    run(mk(BTE_K_RD), 2'h1, 2'h0, 8'h0);
    chk({res, fl & EA}, {BTE_RES_ERR, EA});
    run(mk(BTE_K_RD), 2'h2, 2'h0, 8'h0);
    chk({starts, res}, {32'd2, BTE_RES_OK});
    chk(addr2, 32'h0000_1230);
    $display("test read end");
  endtask : t_rd
  task automatic t_line;
    bte_req_t r;
    r = mk(BTE_K_LINE_RD);
    r.replaces_valid = 1'b1;
    r.dirty_victim = 1'b1;
    r.want_valid = 1'b1;
    r.want_word = 2'h2;
    run(r, 2'h1, 2'h2, 8'h0);
    chk({starts, res}, {32'd1, BTE_RES_ERR});
    chk(fl & (EA | PI | NF | RS | KV), EA | PI | NF | RS);
    r = mk(BTE_K_LINE_RD);
    r.burst_inh = 1'b1;
    r.want_valid = 1'b1;
    r.want_word = 2'h1;
    run(r, 2'h1, 2'h2, 8'h0);
    chk(starts, 32'd3);
    chk(fl & (EA | NF | RS), NF);
    r.misaligned = 1'b1;
    r.want_valid = 1'b0;
    run(r, 2'h1, 2'h1, 8'h0);
    chk(fl & EA, EA);
    r.misaligned = 1'b0;
    run(r, 2'h2, 2'h1, 8'h0);
    chk({starts, res}, {32'd2, BTE_RES_ERR});
    $display("test line end");
  endtask : t_line
  task automatic t_pref;
    bte_req_t r;
    r = mk(BTE_K_RD);
    r.prefetch = 1'b1;
    run(r, 2'h1, 2'h0, 8'h0);
    @(negedge core_clk);
    chk({fl & EA, err_pending_o}, {9'h0, 1'b1});
    pulse(1'b0);
    chk({fl & EA, err_pending_o}, {EA, 1'b0});
    run(r, 2'h1, 2'h0, 8'h0);
    pulse(1'b1);
    chk({fl & EA, err_pending_o}, {9'h0, 1'b0});
    $display("test prefetch end");
  endtask : t_pref
  task automatic t_wr_push;
    bte_req_t r;
    r = mk(BTE_K_WR);
    r.write_thru = 1'b1;
    run(r, 2'h1, 2'h0, 8'h0);
    chk(fl & (WT | EA | LI), WT | EA);
    chk(wr1, 1'b1);
    r.write_thru = 1'b0;
    r.fp_save = 1'b1;
    run(r, 2'h1, 2'h0, 8'h0);
    chk(fl & (FB | EA), FB | EA);
    r = mk(BTE_K_PUSH);
    r.push_after_fill = 1'b1;
    run(r, 2'h1, 2'h0, 8'h0);
    chk(fl & (KV | LI), KV);
    r.push_after_fill = 1'b0;
    r.push_explicit = 1'b1;
    run(r, 2'h1, 2'h0, 8'h0);
    chk(fl & (KV | LI), LI);
    // Line write aborted on its second beat
    r = mk(BTE_K_LINE_WR);
    run(r, 2'h1, 2'h1, 8'h0);
    chk({starts, res}, {32'd1, BTE_RES_ERR});
    chk({fl & EA, wr1}, {EA, 1'b1});
    // Push retried on its first beat: rerun, or dropped when snooped
    r = mk(BTE_K_PUSH);
    run(r, 2'h2, 2'h0, 8'h0);
    chk({starts, res}, {32'd2, BTE_RES_OK});
    @(posedge core_clk);
    snoop <= 1'b1;
    run(r, 2'h2, 2'h0, 8'h0);
    chk({starts, res}, {32'd1, BTE_RES_CANCEL});
    chk(fl & (KV | LI | EA), 9'h0);
    @(posedge core_clk);
    snoop <= 1'b0;
    $display("test write push end");
  endtask : t_wr_push
  task automatic t_tmo;
    run(mk(BTE_K_RD), 2'h3, 2'h0, 8'd40);
    chk(res, BTE_RES_ERR);
    chk(cyc > 40, 1'b1);
    $display("test timeout end");
  endtask : t_tmo
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // Main sequence
  initial begin
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_breakpoint_instr();
    t_rd();
    t_line();
    t_pref();
    t_wr_push();
    t_tmo();
    wrap_up();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #120000;
    err_count++;
    wrap_up();
  end
endmodule : bte_ctrl_tb_top
